// file: hw/bcm_unit.sv
// Purpose: branch evaluation, bit tests, block moves and barrel shift of a DSP core
// Assumes: one clock, synchronous active-low reset, memories held inside this unit
// Notes: a write to the control register executes one instruction; moves take cycles
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module bcm_unit
	import bcm_pkg::*;
#(
	parameter int AW = 8	// memory address bits, depth 2**AW words each
)(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        branch_test_input_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	bcm_regs_s   r;		// all registered state
	bcm_regs_s   n;		// next state
	logic [15:0] dmem [2**AW];	// data memory
	logic [15:0] pmem [2**AW];	// program memory
	logic        dwe;		// data memory write enable
	logic        pwe;		// program memory write enable
	logic [15:0] mwa;		// memory write address
	logic [15:0] mwd;		// memory write data
	logic        go;		// instruction issued this cycle
	logic [31:0] ctl;		// control word being issued
	logic [31:0] wm;		// strobe-merged write data
	logic [31:0] old;		// current value of written register
	logic        werr;		// write refused
	logic [NCOND-1:0] cv;	// truth of each condition now
	logic        taken;		// branch decision
	logic [15:0] mv_word;	// word moved this cycle
	logic [15:0] bitword;	// data word for bit tests

	// memory index from a 16-bit address
	function automatic logic [AW-1:0] aidx(input logic [15:0] a);
		aidx = a[AW-1:0];
	endfunction

	// byte-lane merge of write data over an old value
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				m[i*8 +: 8] = d[i*8 +: 8];
		end
		wmerge = m;
	endfunction

	// condition truth vector, bit order equals branch opcodes
	always_comb
	begin
		cv[0] = (r.acc == 32'h0000_0000);
		cv[1] = !cv[0];
		cv[2] = r.acc[31];
		cv[3] = r.acc[31] || cv[0];
		cv[4] = !r.acc[31] && !cv[0];
		cv[5] = !r.acc[31];
		cv[6] = !r.c;
		cv[7] = r.c;
		cv[8] = !r.ov;
		cv[9] = r.ov;
		cv[10] = r.tc;
		cv[11] = !r.tc;
		cv[12] = !branch_test_input_n;
	end

	// read data words for bit tests and moves
	assign bitword = dmem[aidx(r.src)];
	assign mv_word = (r.op == OP_BLOCK_MOVE_PROGRAM_TO_DATA) ? pmem[aidx(r.mv_s)] : dmem[aidx(r.mv_s)];

	// bus slave, register writes and instruction execution
	always_comb
	begin
		n = r;
		dwe = 1'b0;
		pwe = 1'b0;
		mwa = r.madr;
		mwd = r.wdata[15:0];
		go = 1'b0;
		ctl = r.wdata;
		werr = 1'b0;
		taken = 1'b0;
		// address and data channels taken in either order
		if (r.awready && s_axi_awvalid)
		begin
			n.awready = 1'b0;
			n.aw_have = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid)
		begin
			n.wready = 1'b0;
			n.w_have = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		// old value of the target, for byte-lane merge
		unique case (r.awaddr)
			OFF_STAT: old = {21'h000000, r.slots, r.state == BCM_MOVE, 1'b0, r.aux_register_pointer,
				r.sxm, r.ov, r.c, r.tc};
			OFF_ACC:  old = r.acc;
			OFF_PC:   old = {16'h0000, r.pc};
			OFF_TGT:  old = {16'h0000, r.target};
			OFF_TREG: old = {16'h0000, r.treg};
			OFF_REPEAT_COUNTER: old = {16'h0000, r.repeat_counter};
			OFF_BLOCK_MOVE_ADDRESS_REG: old = {16'h0000, r.block_move_address_reg};
			OFF_SRC:  old = {16'h0000, r.src};
			OFF_DST:  old = {16'h0000, r.dst};
			OFF_AR:   old = {16'h0000, r.ar[r.aux_register_pointer]};
			OFF_MADR: old = {15'h0000, r.mspace, r.madr};
			OFF_COND: old = {19'h00000, r.cond};
			default:  old = 32'h0000_0000;
		endcase
		wm = wmerge(old, r.wdata, r.wstrb);
		ctl = wm;
		// perform the write once both halves are in
		if (r.aw_have && r.w_have && !r.bvalid)
		begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			// everything except plain reads is refused during a move
			if (r.state == BCM_MOVE)
				werr = 1'b1;
			else
			begin
				unique case (r.awaddr)
					OFF_CTRL: go = 1'b1;
					OFF_STAT:
					begin
						n.tc = wm[ST_TC];
						n.c = wm[ST_C];
						n.ov = wm[ST_OV];
						n.sxm = wm[ST_SXM];
						n.aux_register_pointer = wm[ST_ARP +: 3];
					end
					OFF_ACC:  n.acc = wm;
					OFF_PC:   n.pc = wm[15:0];
					OFF_TGT:  n.target = wm[15:0];
					OFF_TREG: n.treg = wm[15:0];
					OFF_REPEAT_COUNTER: n.repeat_counter = wm[15:0];
					OFF_BLOCK_MOVE_ADDRESS_REG: n.block_move_address_reg = wm[15:0];
					OFF_SRC:  n.src = wm[15:0];
					OFF_DST:  n.dst = wm[15:0];
					OFF_AR:   n.ar[r.aux_register_pointer] = wm[15:0];
					OFF_MADR:
					begin
						n.madr = wm[15:0];
						n.mspace = wm[MADR_SPACE];
					end
					OFF_MDAT:
					begin
						// memory window write, address steps on
						dwe = !r.mspace;
						pwe = r.mspace;
						mwd = wm[15:0];
						n.madr = 16'(r.madr + 16'h0001);
					end
					OFF_COND: n.cond = wm[NCOND-1:0];
					default:  werr = 1'b1;
				endcase
			end
			n.bresp = werr ? RESP_ERR : RESP_OK;
		end
		// response taken, reopen the write channels
		if (r.bvalid && s_axi_bready)
		begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end
		// read channel
		if (r.arready && s_axi_arvalid)
		begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = RESP_OK;
			unique case (s_axi_araddr)
				OFF_CTRL: n.rdata = {27'h0000000, r.op};
				OFF_STAT: n.rdata = {21'h000000, r.slots, r.state == BCM_MOVE, 1'b0,
					r.aux_register_pointer, r.sxm, r.ov, r.c, r.tc};
				OFF_ACC:  n.rdata = r.acc;
				OFF_PC:   n.rdata = {16'h0000, r.pc};
				OFF_TGT:  n.rdata = {16'h0000, r.target};
				OFF_TREG: n.rdata = {16'h0000, r.treg};
				OFF_REPEAT_COUNTER: n.rdata = {16'h0000, r.repeat_counter};
				OFF_BLOCK_MOVE_ADDRESS_REG: n.rdata = {16'h0000, r.block_move_address_reg};
				OFF_SRC:  n.rdata = {16'h0000, r.src};
				OFF_DST:  n.rdata = {16'h0000, r.dst};
				OFF_AR:   n.rdata = {16'h0000, r.ar[r.aux_register_pointer]};
				OFF_MADR: n.rdata = {15'h0000, r.mspace, r.madr};
				OFF_MDAT: n.rdata = {16'h0000, r.mspace ? pmem[aidx(r.madr)]
					: dmem[aidx(r.madr)]};
				OFF_COND: n.rdata = {19'h00000, r.cond};
				default:
				begin
					n.rdata = 32'h0000_0000;
					n.rresp = RESP_ERR;
				end
			endcase
		end
		if (r.rvalid && s_axi_rready)
		begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		// instruction issue
		if (go)
		begin
			n.op = ctl[4:0];
			if (ctl[4:0] <= OP_BRANCH_GENERAL_CONDITIONAL)
			begin
				// decide: single condition, unconditional or all of a set
				if (ctl[4:0] == OP_BRANCH_GENERAL_CONDITIONAL)
					taken = &(~r.cond | cv);
				else if (ctl[4:0] == OP_B)
					taken = 1'b1;
				else
					taken = cv[ctl[3:0]];
				// indirect operand side effect on current aux register
				if (ctl[CTL_ARUPD +: 2] == AR_INC)
					n.ar[r.aux_register_pointer] = 16'(r.ar[r.aux_register_pointer] + 16'h0001);
				else if (ctl[CTL_ARUPD +: 2] == AR_DEC)
					n.ar[r.aux_register_pointer] = 16'(r.ar[r.aux_register_pointer] - 16'h0001);
				if (ctl[CTL_ARPLD])
					n.aux_register_pointer = ctl[CTL_NARP +: 3];
				// overflow branch consumes the flag when taken
				if (ctl[4:0] == OP_BV && r.ov)
					n.ov = 1'b0;
				if (ctl[CTL_DLY])
				begin
					// redirect waits for the two following words
					n.slots = DLY_WORDS;
					n.pend_pc = taken ? r.target : 16'(r.pc + BR_WORDS + BR_WORDS);
					n.pc = 16'(r.pc + BR_WORDS);
				end
				else
					n.pc = taken ? r.target : 16'(r.pc + BR_WORDS);
			end
			else
			begin
				unique case (ctl[4:0])
					OP_SLOT:
					begin
						// one or two words executed in the delay slots
						if (r.slots != 2'h0)
						begin
							if (ctl[CTL_ARG] || r.slots == 2'h1)
							begin
								n.slots = 2'h0;
								n.pc = r.pend_pc;
							end
							else
							begin
								n.slots = 2'(r.slots - 2'h1);
								n.pc = 16'(r.pc + 16'h0001);
							end
						end
					end
					OP_BIT: n.tc = bitword[4'(4'hF - ctl[CTL_ARG +: 4])];
					OP_BIT_TEST_REGISTER_SELECTED: n.tc = bitword[4'(4'hF - r.treg[3:0])];
					OP_BLOCK_MOVE_DATA_TO_DATA, OP_BLOCK_MOVE_PROGRAM_TO_DATA, OP_BLOCK_MOVE_DATA_TO_PROGRAM:
					begin
						// start a move with working pointers
						n.state = BCM_MOVE;
						n.mv_s = r.src;
						n.mv_d = (ctl[4:0] == OP_BLOCK_MOVE_DATA_TO_PROGRAM) ? r.block_move_address_reg : r.dst;
					end
					OP_BARREL_SHIFT_RIGHT:
					begin
						// single-cycle right shift by 1..16
						if (r.sxm)
							n.acc = 32'($signed(r.acc) >>> (5'(ctl[CTL_ARG +: 4]) + 5'h01));
						else
							n.acc = r.acc >> (5'(ctl[CTL_ARG +: 4]) + 5'h01);
					end
					default: n.op = r.op;
				endcase
			end
		end
		// block move: one word per cycle until the repeat counter runs out
		if (r.state == BCM_MOVE)
		begin
			mwa = r.mv_d;
			mwd = mv_word;
			pwe = (r.op == OP_BLOCK_MOVE_DATA_TO_PROGRAM);
			dwe = (r.op != OP_BLOCK_MOVE_DATA_TO_PROGRAM);
			n.mv_s = 16'(r.mv_s + 16'h0001);
			n.mv_d = 16'(r.mv_d + 16'h0001);
			if (r.repeat_counter == 16'h0000)
				n.state = BCM_IDLE;
			else
				n.repeat_counter = 16'(r.repeat_counter - 16'h0001);
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
		end
		else
			r <= n;
	end

	// memory arrays
	always_ff @(posedge clk)
	begin
		if (dwe)
			dmem[aidx(mwa)] <= mwd;
		if (pwe)
			pmem[aidx(mwa)] <= mwd;
	end

	// outputs straight from the state register
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;

	// helper: words written during a move against the expected length
	logic [16:0] mv_cnt;
	logic [16:0] mv_len;
	always_ff @(posedge clk)
	begin
		if (go && r.state == BCM_IDLE)
		begin
			mv_cnt <= 17'h00000;
			mv_len <= 17'(r.repeat_counter) + 17'h00001;
		end
		else if (r.state == BCM_MOVE)
			mv_cnt <= 17'(mv_cnt + 17'h00001);
	end

	carry_branch_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == 5'h07 && !ctl[CTL_DLY] |=>
		r.pc == ($past(r.c) ? $past(r.target) : 16'($past(r.pc) + 16'h0002)))
		else $error("carry branch target wrong");
	test_set_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BTC1 && !ctl[CTL_DLY] && r.tc |=> r.pc == $past(r.target))
		else $error("test set branch not taken");
	ov_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BV && r.ov |=> !r.ov && r.pc != $past(r.pc))
		else $error("overflow branch kept flag");
	nov_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BNV |=> r.ov == $past(r.ov))
		else $error("no-overflow branch changed flag");
	test_pin_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BRANCH_ON_TEST_INPUT_LOW && !ctl[CTL_DLY] && branch_test_input_n |=>
		r.pc == 16'($past(r.pc) + 16'h0002))
		else $error("test input branch taken with pin high");
	neg_branch_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BNEG && !ctl[CTL_DLY] && !r.acc[31] |=>
		r.pc == 16'($past(r.pc) + 16'h0002))
		else $error("negative branch taken on positive accumulator");
	delay_slot_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_B && ctl[CTL_DLY] |=> r.slots == 2'h2 ##0
		r.pc == 16'($past(r.pc) + 16'h0002))
		else $error("delayed branch redirected early");
	reg_bit_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BIT_TEST_REGISTER_SELECTED |=> r.tc == $past(bitword[4'(4'hF - r.treg[3:0])]))
		else $error("register bit test copied wrong bit");
	move_len_a: assert property (@(posedge clk) disable iff (!rstn)
		r.state == BCM_IDLE && $past(r.state) == BCM_MOVE |-> mv_cnt == mv_len)
		else $error("block move length wrong");
	shift_sign_a: assert property (@(posedge clk) disable iff (!rstn)
		go && ctl[4:0] == OP_BARREL_SHIFT_RIGHT && r.sxm && r.acc[31] |=> r.acc[31])
		else $error("sign fill lost in barrel shift");
endmodule

// file: pkg/bcm_pkg.sv
// Purpose: constants and state type for the branch / bit-test / block-move unit
// Assumes: AXI4-Lite register access, 16-bit memories inside the unit
// Notes: Summary of operation
package bcm_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_ACC  = 8'h08;
	localparam logic [7:0] OFF_PC   = 8'h0C;
	localparam logic [7:0] OFF_TGT  = 8'h10;
	localparam logic [7:0] OFF_TREG = 8'h14;
	localparam logic [7:0] OFF_REPEAT_COUNTER = 8'h18;
	localparam logic [7:0] OFF_BLOCK_MOVE_ADDRESS_REG = 8'h1C;
	localparam logic [7:0] OFF_SRC  = 8'h20;
	localparam logic [7:0] OFF_DST  = 8'h24;
	localparam logic [7:0] OFF_AR   = 8'h28;
	localparam logic [7:0] OFF_MADR = 8'h2C;
	localparam logic [7:0] OFF_MDAT = 8'h30;
	localparam logic [7:0] OFF_COND = 8'h34;
	// control word fields
	localparam int CTL_DLY = 8;
	localparam int CTL_ARPLD = 9;
	localparam int CTL_ARUPD = 10;
	localparam int CTL_NARP = 12;
	localparam int CTL_ARG = 24;
	localparam int MADR_SPACE = 16;
	// status word fields
	localparam int ST_TC = 0;
	localparam int ST_C = 1;
	localparam int ST_OV = 2;
	localparam int ST_SXM = 3;
	localparam int ST_ARP = 4;
	localparam int ST_BUSY = 8;
	localparam int ST_SLOTS = 9;
	// opcodes 0..12 equal the condition bit they test
	localparam logic [4:0] OP_BNEG = 5'h02;
	localparam logic [4:0] OP_BNV = 5'h08;
	localparam logic [4:0] OP_BV = 5'h09;
	localparam logic [4:0] OP_BTC1 = 5'h0A;
	localparam logic [4:0] OP_BRANCH_ON_TEST_INPUT_LOW = 5'h0C;
	localparam logic [4:0] OP_B = 5'h0D;
	localparam logic [4:0] OP_BRANCH_GENERAL_CONDITIONAL = 5'h0E;
	localparam logic [4:0] OP_BIT = 5'h0F;
	localparam logic [4:0] OP_BIT_TEST_REGISTER_SELECTED = 5'h10;
	localparam logic [4:0] OP_BLOCK_MOVE_DATA_TO_DATA = 5'h11;
	localparam logic [4:0] OP_BLOCK_MOVE_PROGRAM_TO_DATA = 5'h12;
	localparam logic [4:0] OP_BLOCK_MOVE_DATA_TO_PROGRAM = 5'h13;
	localparam logic [4:0] OP_BARREL_SHIFT_RIGHT = 5'h14;
	localparam logic [4:0] OP_SLOT = 5'h15;
	// aux register update modes, delay slot count, responses
	localparam logic [1:0] AR_INC = 2'h1;
	localparam logic [1:0] AR_DEC = 2'h2;
	localparam logic [1:0] DLY_WORDS = 2'h2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [15:0] BR_WORDS = 16'h0002;
	localparam int NCOND = 13;

	typedef enum logic {BCM_IDLE, BCM_MOVE} bcm_state_e;

	typedef struct packed {
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             aw_have;
		logic [7:0]       awaddr;
		logic             w_have;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		bcm_state_e       state;
		logic [4:0]       op;
		logic [31:0]      acc;
		logic [15:0]      pc;
		logic [15:0]      target;
		logic [15:0]      treg;
		logic [15:0]      repeat_counter;
		logic [15:0]      block_move_address_reg;
		logic [15:0]      src;
		logic [15:0]      dst;
		logic [15:0]      mv_s;
		logic [15:0]      mv_d;
		logic [NCOND-1:0] cond;
		logic             tc;
		logic             c;
		logic             ov;
		logic             sxm;
		logic [2:0]       aux_register_pointer;
		logic [7:0][15:0] ar;
		logic [1:0]       slots;
		logic [15:0]      pend_pc;
		logic [15:0]      madr;
		logic             mspace;
	} bcm_regs_s;
endpackage

// file: tb/bcm_mem_model.sv
// Purpose: reference copy of the unit's program and data memories
// Assumes: bench mirrors every window write and block move onto these ports
// Notes: a move held high repeats its copy each edge, which is harmless
`timescale 1ns/1ps
module bcm_mem_model
#(
	parameter int AW = 8	// address bits, same depth as the unit
)(
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic        sp,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wd,
	input  wire logic        mv,
	input  wire logic [1:0]  kind,
	input  wire logic [15:0] src,
	input  wire logic [15:0] dst,
	input  wire logic [15:0] cnt,
	output logic [15:0]      rd
);
	logic [15:0] dm [2**AW];	// data memory
	logic [15:0] pm [2**AW];	// program memory
	logic [15:0] w;	// word in flight
	logic [AW-1:0] sa;	// wrapped source address
	logic [AW-1:0] da;	// wrapped destination address

	// single word writes, then block copies of cnt plus one words
	always @(posedge clk)
	begin
		if (we && sp)
			pm[addr[AW-1:0]] = wd;
		if (we && !sp)
			dm[addr[AW-1:0]] = wd;
		if (mv)
			for (int i = 0; i <= cnt; i++)
			begin
				sa = AW'(src + 16'(i));
				da = AW'(dst + 16'(i));
				w = (kind == 2'h1) ? pm[sa] : dm[sa];
				if (kind == 2'h2)
					pm[da] = w;
				else
					dm[da] = w;
			end
	end

	assign rd = sp ? pm[addr[AW-1:0]] : dm[addr[AW-1:0]];
endmodule

// file: tb/branch_condition_block_move_tb.sv
// Purpose: self-checking bench for the branch, bit-test and block-move unit
// Assumes: register map and opcodes of bcm_pkg, AXI4-Lite master driven here
// Notes: expected memory contents come from the partner model
`timescale 1ns/1ps
module branch_condition_block_move_tb
	import bcm_pkg::*;
;
	logic        clk, rstn, pin_n;	// clock, reset, external test pin
	logic [7:0]  awaddr, araddr;	// bus addresses
	logic [31:0] wdata, rdata, rdat;	// bus data, last read word
	logic [1:0]  bresp, rresp, bresp_v, rresp_v;	// responses, last seen
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        m_we, m_sp, m_mv;	// model controls
	logic [1:0]  m_kind;	// model move kind
	logic [15:0] m_a, m_wd, m_src, m_dst, m_cnt, m_rd;	// model operands
	int          fail_count = 0;
	int          num_checks = 0;
	int          cycles = 0;

	bcm_unit #(.AW(8)) dut (
		.clk(clk), .rstn(rstn), .branch_test_input_n(pin_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	bcm_mem_model #(.AW(8)) mem (
		.clk(clk), .we(m_we), .sp(m_sp), .addr(m_a), .wd(m_wd), .mv(m_mv),
		.kind(m_kind), .src(m_src), .dst(m_dst), .cnt(m_cnt), .rd(m_rd)
	);

	// counts and prints the verdict
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge clk);
			if (awvalid && awready)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready)
			begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do
			@(posedge clk);
		while (!bvalid);
		// bready stays high between writes so no step assigns it twice
		bresp_v = bresp;
	endtask

	// one read, data taken at the edge that sees rvalid
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge clk);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge clk);
		while (!rvalid);
		rdat = rdata;
		// rready stays high between reads so no step assigns it twice
		rresp_v = rresp;
	endtask

	// window write, mirrored into the model
	task automatic mput(input logic sp, input logic [15:0] a, input logic [15:0] d);
		m_sp <= sp;
		m_a <= a;
		m_wd <= d;
		m_we <= 1'b1;
		wr(OFF_MADR, {15'h0, sp, a});
		wr(OFF_MDAT, {16'h0, d});
	endtask

	task automatic mget(input logic sp, input logic [15:0] a);
		m_we <= 1'b0;
		m_sp <= sp;
		m_a <= a;
		wr(OFF_MADR, {15'h0, sp, a});
		rd(OFF_MDAT);
		chk("mem", rdat, {16'h0, m_rd});
	endtask

	// reset values and unmapped offsets
	task automatic t_reset();
		rd(OFF_STAT);
		chk("stat", rdat, 32'h0);
		rd(8'h40);
		chk("rresp", {30'h0, rresp_v}, {30'h0, RESP_ERR});
		wr(8'h44, 32'h1);
		chk("bresp", {30'h0, bresp_v}, {30'h0, RESP_ERR});
	endtask

	// every branch opcode against three flag and accumulator states
	task automatic t_branch();
		logic [31:0] acc;
		logic [3:0]  st;
		logic [13:0] v;
		logic [31:0] e;
		wr(OFF_TGT, 32'h80);
		wr(OFF_COND, 32'h480);
		for (int s = 0; s < 3; s++)
			for (int op = 0; op < 15; op++)
			begin
				acc = (s == 0) ? 32'h0 : (s == 1) ? 32'h8000_0000 : 32'h5;
				st = (s == 0) ? 4'h7 : (s == 1) ? 4'h0 : 4'h2;
				pin_n <= (s == 1);
				wr(OFF_ACC, acc);
				wr(OFF_STAT, {28'h0, st});
				wr(OFF_PC, 32'h10);
				wr(OFF_CTRL, 32'(op));
				v = {1'b1, s != 1, !st[0], st[0], st[2], !st[2], st[1], !st[1], !acc[31],
					!acc[31] && acc != 0, acc[31] || acc == 0, acc[31], acc != 0, acc == 0};
				e = ((op == 14) ? ((v[12:0] & 13'h480) == 13'h480) : v[op]) ? 32'h80 : 32'h12;
				rd(OFF_PC);
				if (op < 6)
					chk("pc acc", rdat, e);
				else if (op < 10)
					chk("pc flag", rdat, e);
				else
					chk("pc test", rdat, e);
				rd(OFF_STAT);
				chk("ovf", {31'h0, rdat[ST_OV]}, {31'h0, st[2] && op != 9});
			end
	endtask

	// indirect operand: increment current aux register, then load pointer 3
	task automatic t_aux();
		wr(OFF_STAT, 32'h0);
		wr(OFF_AR, 32'h5);
		wr(OFF_CTRL, (32'h1 << CTL_ARPLD) | (32'h1 << CTL_ARUPD) | (32'h3 << CTL_NARP) | OP_B);
		rd(OFF_STAT);
		chk("arp", {29'h0, rdat[6:4]}, 32'h3);
		wr(OFF_STAT, 32'h0);
		rd(OFF_AR);
		chk("ar", rdat, 32'h6);
	endtask

	// delayed branch with two one-word slots, then one two-word slot
	task automatic t_delay();
		wr(OFF_PC, 32'h10);
		wr(OFF_CTRL, (32'h1 << CTL_DLY) | OP_B);
		rd(OFF_STAT);
		chk("slots", {30'h0, rdat[10:9]}, {30'h0, DLY_WORDS});
		wr(OFF_CTRL, {27'h0, OP_SLOT});
		rd(OFF_PC);
		chk("pc slot", rdat, 32'h13);
		wr(OFF_CTRL, {27'h0, OP_SLOT});
		rd(OFF_PC);
		chk("pc late", rdat, 32'h80);
		wr(OFF_PC, 32'h10);
		wr(OFF_CTRL, (32'h1 << CTL_DLY) | OP_B);
		wr(OFF_CTRL, (32'h1 << CTL_ARG) | OP_SLOT);
		rd(OFF_PC);
		chk("pc dword", rdat, 32'h80);
	endtask

	// every bit code, direct and through the temporary register
	task automatic t_bit();
		mput(1'b0, 16'h5, 16'h8001);
		wr(OFF_SRC, 32'h5);
		for (int k = 0; k < 16; k++)
		begin
			wr(OFF_CTRL, (32'(k) << CTL_ARG) | OP_BIT);
			rd(OFF_STAT);
			chk("tc bit", {31'h0, rdat[ST_TC]}, {31'h0, k == 0 || k == 15});
			wr(OFF_TREG, 32'hFFF0 | 32'(k));
			wr(OFF_CTRL, {27'h0, OP_BIT_TEST_REGISTER_SELECTED});
			rd(OFF_STAT);
			chk("tc treg", {31'h0, rdat[ST_TC]}, {31'h0, k == 0 || k == 15});
		end
	endtask

	// block move of n plus one words; the word after the block stays put
	task automatic t_move(input logic [1:0] k, input logic [4:0] op, input logic [15:0] s,
		input logic [15:0] d, input logic [15:0] n);
		for (int i = 0; i <= n + 1; i++)
		begin
			mput(k == 2'h1, s + 16'(i), 16'hA500 + 16'(i));
			mput(k == 2'h2, d + 16'(i), 16'h0F0F);
		end
		wr(OFF_REPEAT_COUNTER, {16'h0, n});
		wr(OFF_SRC, {16'h0, s});
		wr(OFF_DST, {16'h0, d});
		wr(OFF_BLOCK_MOVE_ADDRESS_REG, {16'h0, d});
		m_kind <= k;
		m_src <= s;
		m_dst <= d;
		m_cnt <= n;
		m_mv <= 1'b1;
		wr(OFF_CTRL, {27'h0, op});
		if (n > 4)
		begin
			wr(OFF_ACC, 32'h1);
			chk("busy bresp", {30'h0, bresp_v}, {30'h0, RESP_ERR});
		end
		do
			rd(OFF_STAT);
		while (rdat[ST_BUSY] !== 1'b0);
		m_mv <= 1'b0;
		rd(OFF_REPEAT_COUNTER);
		chk("repeat_counter", rdat, 32'h0);
		for (int i = 0; i <= n + 1; i++)
			mget(k == 2'h2, d + 16'(i));
	endtask

	// shift by 1 and by 16, logical and sign-filled
	task automatic t_shift();
		for (int s = 0; s < 2; s++)
		begin
			wr(OFF_STAT, 32'(s) << ST_SXM);
			wr(OFF_ACC, 32'h8000_0010);
			wr(OFF_CTRL, {27'h0, OP_BARREL_SHIFT_RIGHT});
			rd(OFF_ACC);
			chk("acc sh1", rdat, (s == 1) ? 32'hC000_0008 : 32'h4000_0008);
			wr(OFF_ACC, 32'h8000_0010);
			wr(OFF_CTRL, (32'hF << CTL_ARG) | OP_BARREL_SHIFT_RIGHT);
			rd(OFF_ACC);
			chk("acc sh16", rdat, (s == 1) ? 32'hFFFF_8000 : 32'h0000_8000);
		end
	endtask

	// free-running 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard, well above the expected run of some 1400 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	// main sequence
	initial
	begin
		rstn = 1'b0;
		pin_n = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		{m_we, m_sp, m_mv, m_kind} = 5'h0;
		{m_a, m_wd, m_src, m_dst, m_cnt} = 80'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_branch();
		t_aux();
		t_delay();
		t_bit();
		t_move(2'h0, OP_BLOCK_MOVE_DATA_TO_DATA, 16'h20, 16'h40, 16'h2);
		t_move(2'h1, OP_BLOCK_MOVE_PROGRAM_TO_DATA, 16'h30, 16'h50, 16'h7);
		t_move(2'h2, OP_BLOCK_MOVE_DATA_TO_PROGRAM, 16'h60, 16'h70, 16'h0);
		t_shift();
		wrap_up();
	end
endmodule
